//--- verilog/hdmc_pkg.sv
// shared constants and types of the h-bridge dc motor control block
package hdmc_pkg;
  // clock and timing
  localparam longint CLK_FREQ_HZ = 250_000_000;
  localparam longint CHOP_FREQ_HZ = 46_000;
  localparam longint CHOP_FREQ_MIN_HZ = 32_000;
  localparam longint CHOP_FREQ_MAX_HZ = 62_000;
  localparam int CHOP_PERIOD_CYC = int'(CLK_FREQ_HZ / CHOP_FREQ_HZ);
  localparam longint DEAD_TIME_NS = 500;
  localparam int DEAD_CYC = int'((DEAD_TIME_NS * CLK_FREQ_HZ + 999_999_999) / 1_000_000_000);
  localparam longint PIN_FILTER_NS = 40;
  localparam int PIN_FILTER_CYC = int'((PIN_FILTER_NS * CLK_FREQ_HZ + 999_999_999) / 1_000_000_000);
  localparam int DET_FILTER_CYC = 1;
  localparam int CHOP_CNT_W = 16;
  localparam int DEAD_CNT_W = 8;
  // chopping peak current: vref / divide ratio / sense resistance
  localparam real VREF_DIVIDE_RATIO = 4.9;
  localparam real VREF_MAX_V = 2.0;
  localparam real OVERCURRENT_DETECT_V = 0.48;
  // control pin positions in the filtered vector
  localparam int PIN_DIR_A = 0;
  localparam int PIN_DIR_B = 1;
  localparam int PIN_ENABLE = 2;
  localparam int PIN_W = 3;
  localparam int DET_W = 6;

  typedef struct packed {
    logic high_a;
    logic high_b;
    logic low_a;
    logic low_b;
  } hdmc_sw_t;

  typedef struct packed {
    logic short_circ;
    logic over_heat;
    logic over_curr;
    logic rs_short;
    logic vdd_low;
    logic chop_trip;
  } hdmc_det_t;

  typedef enum logic [0:0] {
    DRV_RUN,
    DRV_DEAD
  } hdmc_drv_t;
endpackage

//--- verilog/hdmc_in_filter.sv
// two-flop synchroniser and stability filter, one lane per input bit
`timescale 1ns/1ns
module hdmc_in_filter
  import hdmc_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter int STABLE = 10
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  localparam int CW = $clog2(STABLE + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

  genvar g;
  for (g = 0; g < WIDTH; g++)
  begin : g_lane
    logic meta_reg;
    logic sync_reg;
    logic level_reg;
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end
      else
      begin
        meta_reg <= i_pin[g];
        sync_reg <= meta_reg;
      end
    end

    // level follows only after the synced input held steady
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
      begin
        level_reg <= 1'b0;
        cnt_reg <= '0;
      end
      else if (sync_reg == level_reg)
      begin
        cnt_reg <= '0;
      end
      else if (cnt_reg == LAST)
      begin
        level_reg <= sync_reg;
        cnt_reg <= '0;
      end
      else
      begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end

    assign o_level[g] = level_reg;
  end
endmodule // hdmc_in_filter

//--- verilog/hdmc_bridge_ctrl.sv
// h-bridge switch decode, chopping, dead gap and fault latch
//
// Function
// - direction a low: high a on, low a off
// - direction b low: high b on, low b off
// - both directions low: brake through high switches
// - supply collapse with enable high raises fault
// - short, overheat or overcurrent detector fires: fault low, switches latched off
// - shorted output detected as short, latches off
// - shutdown persists until power cycle
// - shorted sense resistor disables overcurrent only
// - enable may carry external pwm
// - chopping on low switches at internal rate
// - device inserts own gap on reversal
// - peak current is vref over 4.9 over resistor
// - sense voltage over 0.48 v trips overcurrent
// - control pins cleaned by filtered inputs
`timescale 1ns/1ns
module hdmc_bridge_ctrl
  import hdmc_pkg::*;
#(
  parameter int CHOP_PERIOD = CHOP_PERIOD_CYC,
  parameter int DEAD = DEAD_CYC,
  parameter int PIN_STABLE = PIN_FILTER_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_direction_in_a,
  input wire logic i_direction_in_b,
  input wire logic i_enable,
  input wire hdmc_det_t i_detect,
  output hdmc_sw_t o_switch,
  output logic o_fault_n,
  output logic o_chop_active
);
  localparam logic [CHOP_CNT_W-1:0] CHOP_LAST = CHOP_CNT_W'(CHOP_PERIOD - 1);
  localparam logic [DEAD_CNT_W-1:0] DEAD_LAST = DEAD_CNT_W'(DEAD - 1);

  logic [PIN_W-1:0] pin_level;
  hdmc_det_t det;
  logic lvl_a;
  logic lvl_b;
  logic lvl_en;
  hdmc_sw_t req_sw;
  hdmc_sw_t base_reg;
  hdmc_sw_t sw_reg;
  hdmc_drv_t state_reg;
  logic [DEAD_CNT_W-1:0] dead_cnt_reg;
  logic [CHOP_CNT_W-1:0] chop_cnt_reg;
  logic chop_off_reg;
  logic fault_reg;
  logic fault_next;
  logic fault_n_reg;
  logic leg_conflict;

  // clean control levels from the pins
  hdmc_in_filter #(
    .WIDTH(PIN_W),
    .STABLE(PIN_STABLE)
  ) u_pin_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin({i_enable, i_direction_in_b, i_direction_in_a}),
    .o_level(pin_level)
  );

  hdmc_in_filter #(
    .WIDTH(DET_W),
    .STABLE(DET_FILTER_CYC)
  ) u_det_filter (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_detect),
    .o_level(det)
  );

  assign lvl_a = pin_level[PIN_DIR_A];
  assign lvl_b = pin_level[PIN_DIR_B];
  assign lvl_en = pin_level[PIN_ENABLE];

  // requested switch pattern from direction and enable levels
  always_comb
  begin
    req_sw = '0;
    if (!lvl_a && !lvl_b)
    begin
      req_sw.high_a = 1'b1;
      req_sw.high_b = 1'b1;
    end
    else if (lvl_en)
    begin
      req_sw.high_a = !lvl_a;
      req_sw.low_a = lvl_a;
      req_sw.high_b = !lvl_b;
      req_sw.low_b = lvl_b;
    end
  end

  // a switch turning on while its leg partner is still on needs a gap
  assign leg_conflict = (req_sw.high_a && base_reg.low_a) || (req_sw.low_a && base_reg.high_a) ||
                        (req_sw.high_b && base_reg.low_b) || (req_sw.low_b && base_reg.high_b);

  // applied pattern and reversal gap
  always_ff @(posedge i_clk)
  begin
    if (i_rst || fault_reg)
    begin
      state_reg <= DRV_RUN;
      base_reg <= '0;
      dead_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        DRV_RUN:
        begin
          if (leg_conflict)
          begin
            state_reg <= DRV_DEAD;
            base_reg <= '0;
            dead_cnt_reg <= '0;
          end
          else
          begin
            base_reg <= req_sw;
          end
        end
        DRV_DEAD:
        begin
          if (dead_cnt_reg == DEAD_LAST)
          begin
            state_reg <= DRV_RUN;
          end
          dead_cnt_reg <= dead_cnt_reg + DEAD_CNT_W'(1);
        end
        default:
        begin
          state_reg <= DRV_RUN;
          base_reg <= '0;
        end
      endcase
    end
  end

  // internal pwm period; a current trip holds the low switches off till the next period
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      chop_cnt_reg <= '0;
      chop_off_reg <= 1'b0;
    end
    else
    begin
      chop_cnt_reg <= (chop_cnt_reg == CHOP_LAST) ? '0 : chop_cnt_reg + CHOP_CNT_W'(1);
      if (det.chop_trip)
      begin
        chop_off_reg <= 1'b1;
      end
      else if (chop_cnt_reg == CHOP_LAST)
      begin
        chop_off_reg <= 1'b0;
      end
    end
  end

  // fault latch
  assign fault_next = fault_reg || det.short_circ || det.over_heat ||
                      (det.over_curr && !det.rs_short);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      fault_reg <= 1'b0;
      fault_n_reg <= 1'b1;
    end
    else
    begin
      fault_reg <= fault_next;
      fault_n_reg <= !(fault_next || (det.vdd_low && lvl_en));
    end
  end

  // registered switch drive, low side gated by chopping
  always_ff @(posedge i_clk)
  begin
    if (i_rst || fault_reg)
    begin
      sw_reg <= '0;
    end
    else
    begin
      sw_reg.high_a <= base_reg.high_a;
      sw_reg.high_b <= base_reg.high_b;
      sw_reg.low_a <= base_reg.low_a && !chop_off_reg;
      sw_reg.low_b <= base_reg.low_b && !chop_off_reg;
    end
  end

  assign o_switch = sw_reg;
  assign o_fault_n = fault_n_reg;
  assign o_chop_active = chop_off_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_fault_all_off: assert property (fault_reg |=> sw_reg == '0) else $error("switch on during fault");
  a_fault_pin_low: assert property (fault_reg |-> !fault_n_reg) else $error("fault pin high in fault");
  a_fault_sticky: assert property (fault_reg |=> fault_reg [*8]) else $error("fault latch cleared");
  a_short_latches: assert property (det.short_circ |=> fault_reg && !fault_n_reg) else $error("short missed");
  a_ovc_masked: assert property (!fault_reg && det.over_curr && det.rs_short && !det.short_circ && !det.over_heat
    |=> !fault_reg) else $error("overcurrent acted with shorted resistor");
  a_vdd_fault: assert property (det.vdd_low && lvl_en |=> !fault_n_reg) else $error("supply fault not shown");
  a_no_shoot_thru: assert property (!(sw_reg.high_a && sw_reg.low_a) && !(sw_reg.high_b && sw_reg.low_b))
    else $error("leg shoot-through");
  a_chop_low_off: assert property (chop_off_reg |=> !sw_reg.low_a && !sw_reg.low_b)
    else $error("low switch on while chopping");
  a_brake_high: assert property (state_reg == DRV_RUN && base_reg == req_sw && !fault_reg && !lvl_a && !lvl_b
    |-> ##2 (fault_reg || (sw_reg.high_a && sw_reg.high_b && !sw_reg.low_a && !sw_reg.low_b)))
    else $error("brake pattern wrong");
  a_enable_low_off: assert property (!lvl_en && (lvl_a || lvl_b) |-> ##2 sw_reg == '0)
    else $error("switch on with enable low");
  a_forward_drive: assert property (state_reg == DRV_RUN && base_reg == req_sw && lvl_en && lvl_a && !lvl_b
    |-> ##2 (fault_reg || (sw_reg.high_b && !sw_reg.low_b && !sw_reg.high_a))) else $error("forward wrong");
  a_gap_length: assert property (state_reg == DRV_RUN ##1 state_reg == DRV_DEAD |-> state_reg == DRV_DEAD [*2])
    else $error("reversal gap too short");

  c_forward: cover property (sw_reg.low_a && sw_reg.high_b);
  c_reverse: cover property (sw_reg.high_a && sw_reg.low_b);
  c_reversal_gap: cover property (state_reg == DRV_DEAD ##1 state_reg == DRV_RUN);
  c_chop: cover property (chop_off_reg && base_reg.low_a);
  c_fault: cover property (!fault_reg ##1 fault_reg);
endmodule // hdmc_bridge_ctrl

//--- dv/hdmc_host.sv
// host model driving the direction and enable pins of the bridge block
`timescale 1ns/1ns
module hdmc_host
#(
  // enable high width of 16 us and pwm period of 20 us, in 4 ns cycles
  parameter int EN_HIGH_MIN = 4000,
  parameter int EN_PERIOD_MIN = 5000
)
(
  input wire logic i_clk,
  input wire logic [2:0] i_cmd,
  output logic o_direction_in_a,
  output logic o_direction_in_b,
  output logic o_enable
);
  // stop state at power-up: both directions high, enable low
  initial
  begin
    o_direction_in_a = 1'b1;
    o_direction_in_b = 1'b1;
    o_enable = 1'b0;
  end
  // enable high stretched to the minimum width, rises spaced by the minimum pwm period
  logic en_next;
  int high_cnt = 0;
  int since_rise = EN_PERIOD_MIN;
  always @(posedge i_clk)
  begin
    #1;
    if (o_enable)
      en_next = i_cmd[2] || (high_cnt < EN_HIGH_MIN);
    else
      en_next = i_cmd[2] && (since_rise >= EN_PERIOD_MIN);
    high_cnt = en_next ? high_cnt + 1 : 0;
    since_rise = (en_next && !o_enable) ? 1 : since_rise + 1;
    o_direction_in_a <= i_cmd[0];
    o_direction_in_b <= i_cmd[1];
    o_enable <= en_next;
  end
endmodule // hdmc_host

//--- dv/hdmc_bridge_ctrl_test.sv
// self-checking bench of the h-bridge control block
`timescale 1ns/1ns
module hdmc_bridge_ctrl_test
  import hdmc_pkg::*;
();
  localparam int CP = 50;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] cmd = 3'h3;
  hdmc_det_t det = '0;
  logic dir_a;
  logic dir_b;
  logic en;
  hdmc_sw_t sw;
  logic fault_n;
  logic chop;
  int fails = 0;
  int compares = 0;

  hdmc_host #(.EN_HIGH_MIN(16), .EN_PERIOD_MIN(20)) host (.i_clk(i_clk), .i_cmd(cmd),
    .o_direction_in_a(dir_a), .o_direction_in_b(dir_b), .o_enable(en));
  hdmc_bridge_ctrl #(.CHOP_PERIOD(CP), .DEAD(4), .PIN_STABLE(2)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_direction_in_a(dir_a), .i_direction_in_b(dir_b), .i_enable(en), .i_detect(det), .o_switch(sw),
    .o_fault_n(fault_n), .o_chop_active(chop));

  initial
    forever #2 i_clk = ~i_clk;

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk_sw(input hdmc_sw_t g, input hdmc_sw_t e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // bounded wait for the switch pattern to settle
  task automatic wait_sw(input hdmc_sw_t e);
    for (int n = 0; n < 200 && sw !== e; n++)
      cyc(1);
  endtask

  // expected decode: {enable, dir b, dir a}
  function automatic hdmc_sw_t dec(input logic [2:0] c);
    hdmc_sw_t s;
    s = '0;
    if (c[1:0] == 2'h0)
      s = '{1'b1, 1'b1, 1'b0, 1'b0};
    else if (c[2])
      s = '{~c[0], ~c[1], c[0], c[1]};
    return s;
  endfunction

  task automatic do_reset();
    det = '0;
    cmd = 3'h3;
    i_rst = 1'b1;
    cyc(16);
    i_rst = 1'b0;
    chk_bit(fault_n, 1'b1);
  endtask

  task automatic drive(input logic [2:0] c);
    cmd = c;
    // fixed settle span: host edge, sync, filter, reversal gap and both registers
    cyc(20);
    chk_sw(sw, dec(c));
  endtask

  task automatic t_decode();
    for (int i = 0; i < 8; i++)
      drive(3'(i));
    drive(3'h5);
    drive(3'h6);
    $display("decode and reversal done");
  endtask

  task automatic t_chop();
    drive(3'h5);
    det.chop_trip = 1'b1;
    cyc(4);
    det.chop_trip = 1'b0;
    chk_bit(chop, 1'b1);
    cyc(1);
    chk_sw(sw, '{1'b0, 1'b1, 1'b0, 1'b0});
    wait_sw(dec(3'h5));
    chk_sw(sw, dec(3'h5));
    chk_bit(chop, 1'b0);
    $display("chopping done");
  endtask

  task automatic t_pwm();
    for (int p = 0; p < 3; p++)
    begin
      drive(3'h1);
      drive(3'h5);
    end
    $display("external pwm done");
  endtask

  task automatic t_faults();
    for (int k = 0; k < 3; k++)
    begin
      do_reset();
      drive(3'h5);
      det = hdmc_det_t'(6'h20 >> k);
      cyc(8);
      chk_bit(fault_n, 1'b0);
      chk_sw(sw, '0);
      det = '0;
      cmd = 3'h6;
      cyc(40);
      chk_sw(sw, '0);
      chk_bit(fault_n, 1'b0);
    end
    do_reset();
    drive(3'h5);
    $display("fault latch done");
  endtask

  task automatic t_rs_short();
    det = 6'h0c;
    cyc(20);
    chk_bit(fault_n, 1'b1);
    chk_sw(sw, dec(3'h5));
    det.short_circ = 1'b1;
    cyc(8);
    chk_bit(fault_n, 1'b0);
    $display("sense short done");
  endtask

  task automatic t_vdd();
    do_reset();
    drive(3'h5);
    det.vdd_low = 1'b1;
    cyc(8);
    chk_bit(fault_n, 1'b0);
    det.vdd_low = 1'b0;
    cyc(8);
    chk_bit(fault_n, 1'b1);
    drive(3'h3);
    det.vdd_low = 1'b1;
    cyc(8);
    chk_bit(fault_n, 1'b1);
    det.vdd_low = 1'b0;
    $display("supply collapse done");
  endtask

  // no leg may ever have both switches on
  always @(negedge i_clk)
    if (!i_rst && ((sw.high_a && sw.low_a) || (sw.high_b && sw.low_b)))
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, sw, 4'h0);
    end

  initial
  begin
    #20000;
    fails++;
    $display("watchdog expired");
    end_of_test();
  end

  initial
  begin
    do_reset();
    t_decode();
    t_chop();
    t_pwm();
    t_vdd();
    t_faults();
    t_rs_short();
    end_of_test();
  end
endmodule // hdmc_bridge_ctrl_test
